/* core/fault_flag_bit.v */
// One fault flag with its companion ack bit.
// Assumes a single clock, sync reset, and a one-cycle write strobe.
`timescale 1ns/1ps
`default_nettype none
module fault_flag_bit
(
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Fault event from the detector, one cycle or level
    input wire fault_event,
    // Host write to the flag/ack pair
    input wire wr_en,
    input wire wr_flag,
    input wire wr_ack,
    // State
    output wire flag
);
    reg flag_q;
    reg flag_d;

    // A new fault wins over a clear in the same cycle so no event is lost
    always @*
    begin
        flag_d = flag_q;
        if (wr_en && wr_flag && wr_ack)
        begin
            flag_d = 1'b0;
        end
        if (fault_event)
        begin
            flag_d = 1'b1;
        end
    end

    // Flag register
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule
`default_nettype wire

/* core/fault_temp_regbank.v */
// Fault flag register and die temperature registers of a backlight driver.
// Assumes a register access port on core_clk: one-cycle write or read strobes with
// address and data, read data valid the cycle after the read strobe.
// Fault detectors are asynchronous levels; the converter result is on core_clk.
// The interrupt output is a plain level; any pin driver and its polarity sit
// outside this block. A flag needs a fresh rising detector level to set again.
// Only the low TEMP_W bits of a threshold write are kept.
`timescale 1ns/1ps
`default_nettype none
`include "fault_temp_regs.vh"
module fault_temp_regbank
#(
    parameter ADDR_W = 12,
    parameter TEMP_W = `TEMP_W
)
(
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Register access port
    input wire reg_wr,
    input wire reg_rd,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    output wire [15:0] reg_rdata,
    output wire reg_rvalid,
    // Fault detector levels, asynchronous
    input wire sync_loss_det,
    input wire supply_overcurrent_det,
    input wire pump_capacitor_missing_det,
    input wire pump_fault_det,
    input wire freq_resistor_missing_det,
    input wire bad_string_config_det,
    input wire supply_overvoltage_det,
    input wire supply_undervoltage_det,
    // Converter result, same clock
    input wire temp_sample_valid,
    input wire [TEMP_W-1:0] temp_sample,
    // Outputs to the rest of the device
    output wire fault_irq,
    output wire [TEMP_W-1:0] temp_upper_limit,
    output wire [TEMP_W-1:0] temp_lower_limit,
    output wire temp_above_upper,
    output wire temp_below_lower
);
    wire [7:0] det_async;
    wire [7:0] det_sync;
    wire [7:0] flags;
    wire fault_wr;
    reg [7:0] det_prev_q;
    reg [TEMP_W-1:0] temp_q;
    reg [TEMP_W-1:0] upper_q;
    reg [TEMP_W-1:0] lower_q;
    reg [15:0] rdata_q;
    reg rvalid_q;
    reg irq_q;
    reg above_q;
    reg below_q;
    reg [15:0] rdata_d;
    wire [7:0] fault_rise;
    wire upper_wr;
    wire lower_wr;
    wire [15:0] fault_view;
    wire [15:0] temp_view;
    wire [15:0] upper_view;
    wire [15:0] lower_view;
    genvar i;

    // Reserved bits above a temperature field
    localparam PAD_W = 16 - TEMP_W;

    // Detector order matches flag positions from high to low
    assign det_async = {sync_loss_det, supply_overcurrent_det,
                        pump_capacitor_missing_det, pump_fault_det,
                        freq_resistor_missing_det, bad_string_config_det,
                        supply_overvoltage_det, supply_undervoltage_det};

    // Pin levels cross into core_clk through three stages; a glitch shorter
    // than two clock periods can be missed, which suits slow fault detectors
    pin_sync3 #(
        .WIDTH(`FAULT_NUM)
    ) u_det_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(det_async),
        .sync_out(det_sync)
    );

    // Rising detector edges set flags, so a cleared flag stays clear while
    // the fault merely persists; a fresh fault re-arms it
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            det_prev_q <= 8'h00;
        end
        else
        begin
            det_prev_q <= det_sync;
        end
    end

    // Rising edge of each synchronised detector level
    assign fault_rise = det_sync & ~det_prev_q;

    // Write decodes; nothing decodes a write to the measurement register,
    // so the converter stays its only writer
    assign fault_wr = reg_wr && (reg_addr == `OFS_FAULT_FLAGS_THREE);
    assign upper_wr = reg_wr && (reg_addr == `OFS_DIE_TEMP_UPPER);
    assign lower_wr = reg_wr && (reg_addr == `OFS_DIE_TEMP_LOWER);

    // One flag cell per fault; flag k lives at bit 2k+1, ack at 2k
    // A fault and a clearing write in one cycle leave the flag set
    generate
        for (i = 0; i < `FAULT_NUM; i = i + 1)
        begin : g_flag
            fault_flag_bit u_flag (
                .core_clk(core_clk),
                .reset(reset),
                .fault_event(fault_rise[i]),
                .wr_en(fault_wr),
                .wr_flag(reg_wdata[2*i+1]),
                .wr_ack(reg_wdata[2*i]),
                .flag(flags[i])
            );
        end
    endgenerate

    // Interrupt follows the OR of all flags; registered so the output
    // cannot glitch while several flags change at once
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |flags;
        end
    end

    // Temperature measurement: hardware only, host writes have no effect;
    // the reading holds its last sample between converter pulses
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            temp_q <= `RST_DIE_TEMP;
        end
        else if (temp_sample_valid)
        begin
            temp_q <= temp_sample;
        end
    end

    // Upper threshold: only the field bits are kept, reserved bits read zero
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            upper_q <= `RST_TEMP_UPPER;
        end
        else if (upper_wr)
        begin
            upper_q <= reg_wdata[TEMP_W-1:0];
        end
    end

    // Lower threshold, same encoding as the upper one
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            lower_q <= `RST_TEMP_LOWER;
        end
        else if (lower_wr)
        begin
            lower_q <= reg_wdata[TEMP_W-1:0];
        end
    end

    // Signed compares treat codes 100h-1FFh as negative degrees
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            above_q <= 1'b0;
        end
        else
        begin
            above_q <= $signed(temp_q) > $signed(upper_q);
        end
    end

    // The reset reading is -256 degrees, so this flag rises just after reset
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            below_q <= 1'b0;
        end
        else
        begin
            below_q <= $signed(temp_q) < $signed(lower_q);
        end
    end

    // Fault register view; ack bits are not stored and read zero, so a
    // read-modify-write of the register can never clear a flag by accident
    generate
        for (i = 0; i < `FAULT_NUM; i = i + 1)
        begin : g_view
            assign fault_view[2*i+1] = flags[i];
            assign fault_view[2*i] = 1'b0;
        end
    endgenerate

    // Reserved upper bits read zero whatever the host wrote there
    assign temp_view = {{PAD_W{1'b0}}, temp_q};
    assign upper_view = {{PAD_W{1'b0}}, upper_q};
    assign lower_view = {{PAD_W{1'b0}}, lower_q};

    // Read mux; unmapped addresses read zero
    always @*
    begin
        rdata_d = 16'h0000;
        case (reg_addr)
            `OFS_FAULT_FLAGS_THREE:
            begin
                rdata_d = fault_view;
            end
            `OFS_DIE_TEMP_READING:
            begin
                rdata_d = temp_view;
            end
            `OFS_DIE_TEMP_UPPER:
            begin
                rdata_d = upper_view;
            end
            `OFS_DIE_TEMP_LOWER:
            begin
                rdata_d = lower_view;
            end
            default:
            begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    // Read strobe echoed one cycle later as the valid pulse
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= reg_rd;
        end
    end

    // Read data is held until the next read, so a slow host may sample late
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            rdata_q <= 16'h0000;
        end
        else if (reg_rd)
        begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs come straight from flip-flops
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign fault_irq = irq_q;
    assign temp_upper_limit = upper_q;
    assign temp_lower_limit = lower_q;
    assign temp_above_upper = above_q;
    assign temp_below_lower = below_q;
endmodule
`default_nettype wire

/* core/pin_sync3.v */
// Three-stage synchroniser for a bus of asynchronous levels.
// A bit changes at the output only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
#(
    parameter WIDTH = 8
)
(
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Asynchronous input and synchronised output
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    genvar i;

    // Shift chain; the first stage feeds only the second
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change per bit once stages two and three agree
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_agree
            // One flip-flop per bit, so each output bit has a single driver
            reg agree_q;
            always @(posedge core_clk)
            begin
                if (reset)
                begin
                    agree_q <= 1'b0;
                end
                else if (s2_q[i] == s3_q[i])
                begin
                    agree_q <= s3_q[i];
                end
            end
            assign sync_out[i] = agree_q;
        end
    endgenerate
endmodule
`default_nettype wire

/* include/fault_temp_regs.vh */
// Constants for the fault flag register and the die temperature registers.
// Included by the fault_temp_regbank core only; definitions only.
`ifndef FAULT_TEMP_REGS_VH
`define FAULT_TEMP_REGS_VH

// Register offsets on the register access port
`define OFS_FAULT_FLAGS_THREE 12'h058
`define OFS_DIE_TEMP_READING 12'h0E8
`define OFS_DIE_TEMP_UPPER 12'h0EC
`define OFS_DIE_TEMP_LOWER 12'h0EE

// Fault flag positions, each ack bit sits one below its flag
`define BIT_SYNC_LOSS 15
`define BIT_SUPPLY_OVERCURRENT 13
`define BIT_PUMP_CAP_MISSING 11
`define BIT_PUMP_FAULT 9
`define BIT_FREQ_RES_MISSING 7
`define BIT_BAD_STRING_CONFIG 5
`define BIT_SUPPLY_OVERVOLTAGE 3
`define BIT_SUPPLY_UNDERVOLTAGE 1

// Reset values
`define RST_FAULT_FLAGS 16'h0000
`define RST_DIE_TEMP 9'h100
`define RST_TEMP_UPPER 9'h07D
`define RST_TEMP_LOWER 9'h069

// Field widths
`define TEMP_W 9
`define FAULT_NUM 8

`endif

/* tb/host_model.sv */
// Behavioural host on the register port of the fault/temperature bank.
// The bench calls xfer; requests launch just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    // Clock
    input wire logic core_clk,
    // Register port towards the bank
    output var logic reg_wr = 1'b0,
    output var logic reg_rd = 1'b0,
    output var logic [11:0] reg_addr = 12'h000,
    output var logic [15:0] reg_wdata = 16'h0000,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    // One strobe per call; bus lines are inverted once taken so the bank
    // cannot lean on stale values. Read data is taken at the edge after the
    // strobe, while rvalid stands, and only counts with rvalid.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge core_clk);
        q = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

/* tb/regbank_props.sv */
// Port checks for the fault flag and die temperature register bank.
// Bound into fault_temp_regbank; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module regbank_props
#(
    parameter ADDR_W = 12
)
(
    // Clock, reset and register port
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // Device side outputs
    input wire logic fault_irq,
    input wire logic [8:0] temp_upper_limit
);
    // Address decodes used by the properties below
    wire clr_wr = reg_wr && reg_addr == 12'h058;
    wire hi_wr = reg_wr && reg_addr == 12'h0EC;
    wire mapped = reg_addr inside {12'h058, 12'h0E8, 12'h0EC, 12'h0EE};
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    property p_rst;
        disable iff (1'b0) reset |=> temp_upper_limit == 9'h07D && !fault_irq;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_rv;
        reg_rd ##1 !reg_rd |-> reg_rvalid ##1 !reg_rvalid;
    endproperty
    a_rv: assert property (p_rv) else $error("rvalid timing");
    // The pin only drops two or three cycles after a clearing write
    property p_fell;
        $fell(fault_irq) |-> $past(clr_wr, 2) || $past(clr_wr, 3);
    endproperty
    a_fell: assert property (p_fell) else $error("irq dropped alone");
    property p_wr_hi;
        hi_wr |=> {7'h00, temp_upper_limit} == ($past(reg_wdata) & 16'h01FF);
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("upper limit write");
    property p_hold_hi;
        !hi_wr |=> $stable(temp_upper_limit);
    endproperty
    a_hold_hi: assert property (p_hold_hi) else $error("upper limit moved");
    property p_rd_tmp;
        reg_rd && reg_addr == 12'h0E8 |=> reg_rdata[15:9] == 7'h00;
    endproperty
    a_rd_tmp: assert property (p_rd_tmp) else $error("reading high bits");
    property p_unmap;
        reg_rd && !mapped |=> reg_rdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_rd_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
endmodule
bind fault_temp_regbank regbank_props #(.ADDR_W(ADDR_W)) chk (
    .core_clk(core_clk),
    .reset(reset),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .fault_irq(fault_irq),
    .temp_upper_limit(temp_upper_limit)
);
`default_nettype wire

/* tb/test_fault_flags_and_die_temp_regs.sv */
// Self-checking bench for fault_temp_regbank, host side in host_model.
// Detector and converter inputs are driven from here.
`timescale 1ns/1ps
`default_nettype none
module test_fault_flags_and_die_temp_regs;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic t_valid = 1'b0;
    logic wr, rd, rvalid, irq, above, below;
    logic [11:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [8:0] t_smp = 9'h000;
    logic [8:0] tv, lv, lw, up_lim, lo_lim;
    logic [7:0] det = 8'h00;
    logic [31:0] seed = 32'h568f_be88;
    logic [11:0] ra[4] = '{12'h058, 12'h0E8, 12'h0EC, 12'h0EE};
    logic [15:0] rv[4] = '{16'h0000, 16'h0100, 16'h007D, 16'h0069};
    int errors = 0;
    int checked = 0;
    // Host on the register port
    host_model host (.core_clk(core_clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
    // Bank under test; det[k] feeds the flag at bit 2k+1
    fault_temp_regbank DUT (.core_clk(core_clk), .reset(reset), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .sync_loss_det(det[7]), .supply_overcurrent_det(det[6]),
        .pump_capacitor_missing_det(det[5]), .pump_fault_det(det[4]),
        .freq_resistor_missing_det(det[3]), .bad_string_config_det(det[2]),
        .supply_overvoltage_det(det[1]), .supply_undervoltage_det(det[0]),
        .temp_sample_valid(t_valid), .temp_sample(t_smp), .fault_irq(irq),
        .temp_upper_limit(up_lim), .temp_lower_limit(lo_lim), .temp_above_upper(above),
        .temp_below_lower(below));
    // LFSR step with a fixed start, so every run is the same
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction
    // Expected compare: both sides are signed nine-bit degrees
    function automatic logic hot(input logic [8:0] t, input logic [8:0] l);
        return $signed(t) > $signed(l);
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Clock at 125 MHz
    initial
        forever #4 core_clk = ~core_clk;
    // Watchdog, far beyond the scripted run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        print_verdict;
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            host.xfer(1'b0, ra[i], 16'h0000, v);
            chk("reset value", v, rv[i]);
        end
        // Each fault in turn; its level stays high across the clear
        for (int k = 0; k < 8; k++)
        begin
            det[k] <= 1'b1;
            repeat (8) @(posedge core_clk);
            host.xfer(1'b0, 12'h058, 16'h0000, v);
            chk("flag set", v, 16'h0002 << 2 * k);
            chk("irq set", irq, 16'h0001);
            host.xfer(1'b1, 12'h058, 16'h0002 << 2 * k, v);
            host.xfer(1'b0, 12'h058, 16'h0000, v);
            chk("flag alone", v, 16'h0002 << 2 * k);
            host.xfer(1'b1, 12'h058, 16'h0003 << 2 * k, v);
            repeat (2) @(posedge core_clk);
            #1;
            chk("irq clear", irq, 16'h0000);
            host.xfer(1'b0, 12'h058, 16'h0000, v);
            chk("flag clear", v, 16'h0000);
            det[k] <= 1'b0;
        end
        // Two faults: acking one must leave the interrupt up; the detectors
        // first rest low long enough to pass the synchroniser
        repeat (8) @(posedge core_clk);
        det <= 8'h81;
        repeat (8) @(posedge core_clk);
        host.xfer(1'b1, 12'h058, 16'h0003, v);
        repeat (3) @(posedge core_clk);
        #1;
        chk("irq held", irq, 16'h0001);
        host.xfer(1'b1, 12'h058, 16'hC000, v);
        det <= 8'h00;
        repeat (2) @(posedge core_clk);
        chk("irq last clear", irq, 16'h0000);
        // Samples and limits; the first pair is the signed corner
        for (int i = 0; i < 6; i++)
        begin
            seed = step(seed);
            tv = i ? seed[24:16] : 9'h0FF;
            lv = i ? seed[8:0] : 9'h100;
            lw = i ? seed[31:23] : 9'h1FF;
            t_smp <= tv;
            t_valid <= 1'b1;
            @(posedge core_clk);
            t_valid <= 1'b0;
            host.xfer(1'b1, 12'h0EC, {seed[15:9], lv}, v);
            host.xfer(1'b1, 12'h0EE, {seed[22:16], lw}, v);
            host.xfer(1'b1, 12'h0E8, ~seed[15:0], v);
            chk("above", above, hot(tv, lv));
            chk("below", below, hot(lw, tv));
            chk("upper pin", up_lim, lv);
            chk("lower pin", lo_lim, lw);
            host.xfer(1'b0, 12'h0EC, 16'h0000, v);
            chk("upper", v, {7'h00, lv});
            host.xfer(1'b0, 12'h0EE, 16'h0000, v);
            chk("lower", v, {7'h00, lw});
            host.xfer(1'b0, 12'h0E8, 16'h0000, v);
            chk("reading", v, {7'h00, tv});
        end
        host.xfer(1'b0, 12'h100, 16'h0000, v);
        chk("unmapped", v, 16'h0000);
        print_verdict;
    end
endmodule
`default_nettype wire
